/* File: hw/gpiop_defines.svh */
`ifndef GPIOP_DEFINES_SVH
`define GPIOP_DEFINES_SVH
`define GPIOP_WIDTH 8
`define GPIOP_OFS_PIN 8'h00
`define GPIOP_OFS_DIR 8'h04
`define GPIOP_OFS_LATCH 8'h08
`define GPIOP_OFS_CTRL 8'h0C
`define GPIOP_OFS_INT_EN 8'h10
`define GPIOP_OFS_INT_EDGE 8'h14
`define GPIOP_OFS_INT_FLAG 8'h18
`define GPIOP_PUD_BIT 0
`define GPIOP_RST_BYTE 8'h00
`define GPIOP_RST_PUD 1'b0
`define GPIOP_RST_WORD 32'h0000_0000
`endif

/* File: hw/gpiop_pkg.sv */
`include "gpiop_defines.svh"
package gpiop_pkg;
  typedef logic [`GPIOP_WIDTH-1:0] gpiop_byte_t;
  typedef struct packed {
    gpiop_byte_t out;
    gpiop_byte_t oe;
    gpiop_byte_t pullup_en;
  } gpiop_pad_t;
  typedef struct packed {
    logic port_write_strobe;
    logic pin_register_write_strobe;
    logic direction_write_strobe;
    logic port_read_strobe;
    logic pin_read_strobe;
    logic direction_read_strobe;
  } gpiop_strobe_t;
  typedef enum logic [3:0] {
    GPIOP_ST_IDLE = 4'h1,
    GPIOP_ST_WRITE = 4'h2,
    GPIOP_ST_RD_WAIT = 4'h4,
    GPIOP_ST_RD_DONE = 4'h8
  } gpiop_bus_state_t;
endpackage

/* File: hw/gpiop_port.sv */
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "gpiop_defines.svh"
module gpiop_port (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pads
  input wire gpiop_pkg::gpiop_byte_t pad_in,
  output gpiop_pkg::gpiop_pad_t pad,
  // Sleep and alternate functions
  input wire logic sleep_clamp,
  input wire gpiop_pkg::gpiop_byte_t alt_input_override
);

  function automatic logic gpiop_hit(input logic [7:0] addr, input logic [7:0] ofs);
    gpiop_hit = (addr == ofs);
  endfunction

  gpiop_pkg::gpiop_bus_state_t state_q;
  logic [7:0] dp_addr_q;
  logic [31:0] hrdata_q;
  gpiop_pkg::gpiop_byte_t direction_q;
  gpiop_pkg::gpiop_byte_t latch_q;
  logic pud_q;
  gpiop_pkg::gpiop_byte_t int_en_q;
  gpiop_pkg::gpiop_byte_t int_edge_q;
  gpiop_pkg::gpiop_byte_t int_flag_q;
  logic sleep_q;
  gpiop_pkg::gpiop_byte_t pin_q;
  gpiop_pkg::gpiop_byte_t sync_in;
  gpiop_pkg::gpiop_byte_t clamp_mask;
  gpiop_pkg::gpiop_byte_t wdata;
  gpiop_pkg::gpiop_byte_t rd_byte;
  gpiop_pkg::gpiop_byte_t wake_set;
  gpiop_pkg::gpiop_strobe_t strb;
  logic accept;
  logic wr_phase;
  logic rd_phase;
  logic ctrl_wr;
  logic int_en_wr;
  logic int_edge_wr;
  logic int_flag_wr;
  logic wake;

  assign wdata = hwdata[`GPIOP_WIDTH-1:0];
  assign accept = hsel && htrans[1] && hready;
  assign wr_phase = (state_q == gpiop_pkg::GPIOP_ST_WRITE);
  assign rd_phase = (state_q == gpiop_pkg::GPIOP_ST_RD_WAIT);

  // Bus transfer sequencing; reads take one wait state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= gpiop_pkg::GPIOP_ST_IDLE;
    end else if (clk_en) begin
      case (state_q)
        gpiop_pkg::GPIOP_ST_IDLE, gpiop_pkg::GPIOP_ST_WRITE, gpiop_pkg::GPIOP_ST_RD_DONE: begin
          if (accept && hwrite) begin
            state_q <= gpiop_pkg::GPIOP_ST_WRITE;
          end else if (accept) begin
            state_q <= gpiop_pkg::GPIOP_ST_RD_WAIT;
          end else begin
            state_q <= gpiop_pkg::GPIOP_ST_IDLE;
          end
        end
        gpiop_pkg::GPIOP_ST_RD_WAIT: begin
          state_q <= gpiop_pkg::GPIOP_ST_RD_DONE;
        end
        default: begin
          state_q <= gpiop_pkg::GPIOP_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dp_addr_q <= 8'h00;
    end else if (clk_en && accept) begin
      dp_addr_q <= haddr[7:0];
    end
  end

  assign hreadyout = !rd_phase;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Shared port strobes
  always_comb begin
    strb.port_write_strobe = wr_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_LATCH);
    strb.pin_register_write_strobe = wr_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_PIN);
    strb.direction_write_strobe = wr_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_DIR);
    strb.port_read_strobe = rd_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_LATCH);
    strb.pin_read_strobe = rd_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_PIN);
    strb.direction_read_strobe = rd_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_DIR);
  end

  assign ctrl_wr = wr_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_CTRL);
  assign int_en_wr = wr_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_INT_EN);
  assign int_edge_wr = wr_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_INT_EDGE);
  assign int_flag_wr = wr_phase && gpiop_hit(dp_addr_q, `GPIOP_OFS_INT_FLAG);

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_byte = `GPIOP_RST_BYTE;
    if (strb.pin_read_strobe) begin
      rd_byte = pin_q;
    end else if (strb.direction_read_strobe) begin
      rd_byte = direction_q;
    end else if (strb.port_read_strobe) begin
      rd_byte = latch_q;
    end else if (gpiop_hit(dp_addr_q, `GPIOP_OFS_CTRL)) begin
      rd_byte[`GPIOP_PUD_BIT] = pud_q;
    end else if (gpiop_hit(dp_addr_q, `GPIOP_OFS_INT_EN)) begin
      rd_byte = int_en_q;
    end else if (gpiop_hit(dp_addr_q, `GPIOP_OFS_INT_EDGE)) begin
      rd_byte = int_edge_q;
    end else if (gpiop_hit(dp_addr_q, `GPIOP_OFS_INT_FLAG)) begin
      rd_byte = int_flag_q;
    end
  end

  // Sampled in the wait state so a preceding write is visible
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= `GPIOP_RST_WORD;
    end else if (clk_en && rd_phase) begin
      hrdata_q <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      direction_q <= `GPIOP_RST_BYTE;
    end else if (clk_en && strb.direction_write_strobe) begin
      direction_q <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= `GPIOP_RST_BYTE;
    end else if (clk_en && strb.port_write_strobe) begin
      latch_q <= wdata;
    end else if (clk_en && strb.pin_register_write_strobe) begin
      latch_q <= latch_q ^ wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pud_q <= `GPIOP_RST_PUD;
    end else if (clk_en && ctrl_wr) begin
      pud_q <= wdata[`GPIOP_PUD_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_en_q <= `GPIOP_RST_BYTE;
      int_edge_q <= `GPIOP_RST_BYTE;
    end else if (clk_en) begin
      if (int_en_wr) begin
        int_en_q <= wdata;
      end
      if (int_edge_wr) begin
        int_edge_q <= wdata;
      end
    end
  end

  // Wake from clamped sleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep_q <= 1'b0;
    end else if (clk_en) begin
      sleep_q <= sleep_clamp;
    end
  end

  assign wake = sleep_q && !sleep_clamp;
  assign wake_set = {`GPIOP_WIDTH{wake}} & ~int_en_q & int_edge_q & pad_in;

  // Write one clears; a set in the same cycle wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_flag_q <= `GPIOP_RST_BYTE;
    end else if (clk_en) begin
      int_flag_q <= (int_flag_q & ~(int_flag_wr ? wdata : `GPIOP_RST_BYTE)) | wake_set;
    end
  end

  // Input clamp ahead of the synchronizer
  assign clamp_mask = {`GPIOP_WIDTH{sleep_clamp}} & ~(int_en_q | alt_input_override);
  assign sync_in = pad_in & ~clamp_mask;

  gpiop_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din(sync_in),
    .sync_q(pin_q)
  );

  // Pad drivers; reset gates them without a clock
  always_comb begin
    pad.oe = direction_q & {`GPIOP_WIDTH{rst_n}};
    pad.out = latch_q & {`GPIOP_WIDTH{rst_n}};
    pad.pullup_en = {`GPIOP_WIDTH{rst_n && !pud_q}} & ~direction_q & latch_q;
  end

  AST_OE_FOLLOWS_DIR: assert property (@(posedge clock) disable iff (!rst_n)
    pad.oe == direction_q)
    else $error("pad enable differs from direction");

  AST_PULLUP_TABLE: assert property (@(posedge clock) disable iff (!rst_n)
    pad.pullup_en == (~direction_q & latch_q & {`GPIOP_WIDTH{!pud_q}}))
    else $error("pull-up enable wrong");

  AST_NO_PULLUP_ON_OUTPUT: assert property (@(posedge clock) disable iff (!rst_n)
    (pad.pullup_en & (direction_q | ~latch_q)) == `GPIOP_RST_BYTE)
    else $error("pull-up on while driving or latch zero");

  AST_DRIVE_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
    ((pad.out ^ latch_q) & pad.oe) == `GPIOP_RST_BYTE)
    else $error("driven level differs from latch");

  AST_TOGGLE: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && strb.pin_register_write_strobe) |=> latch_q == ($past(latch_q) ^ $past(wdata)))
    else $error("pin write did not toggle latch");

  AST_PUD_ALL: assert property (@(posedge clock) disable iff (!rst_n)
    pud_q |-> pad.pullup_en == `GPIOP_RST_BYTE)
    else $error("pull-up active with global disable");

  AST_SYNC_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(clk_en) && $past(rst_n)) |-> pin_q == $past(sync_in))
    else $error("synchronizer latency wrong");

  AST_CLAMP: assert property (@(posedge clock) disable iff (!rst_n)
    sleep_clamp |-> (sync_in & ~(int_en_q | alt_input_override)) == `GPIOP_RST_BYTE)
    else $error("clamped input not low");

  AST_WAKE_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && wake) |=> (int_flag_q & $past(wake_set)) == $past(wake_set))
    else $error("wake flag not set");

  AST_RESET_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> (pad.oe == `GPIOP_RST_BYTE) && (pad.pullup_en == `GPIOP_RST_BYTE))
    else $error("pins not quiet after reset");

  AST_READ_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  AST_DIR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && strb.direction_write_strobe) |=> direction_q == $past(wdata))
    else $error("direction write lost");

  AST_LATCH_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && strb.port_write_strobe) |=> latch_q == $past(wdata))
    else $error("latch write lost");

  AST_TOGGLE_KEEPS_DIR: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && strb.pin_register_write_strobe) |=> direction_q == $past(direction_q))
    else $error("pin write changed direction");

  AST_PUD_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && ctrl_wr) |=> pud_q == $past(wdata[`GPIOP_PUD_BIT]))
    else $error("pull-up disable write lost");

  AST_PIN_READ: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && strb.pin_read_strobe) |=> hrdata == {24'h00_0000, $past(pin_q)})
    else $error("pin read data wrong");

  AST_DIR_READ: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && strb.direction_read_strobe) |=> hrdata == {24'h00_0000, $past(direction_q)})
    else $error("direction read data wrong");

  AST_LATCH_READ: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && strb.port_read_strobe) |=> hrdata == {24'h00_0000, $past(latch_q)})
    else $error("latch read data wrong");

  AST_WRITE_NO_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && accept && hwrite) |=> hreadyout)
    else $error("write inserted a wait state");

  AST_WAIT_ONLY_READ: assert property (@(posedge clock) disable iff (!rst_n)
    (!hreadyout && $past(clk_en)) |-> ($past(accept) && !$past(hwrite)))
    else $error("wait state without a read");

  AST_CLAMP_OFF_AWAKE: assert property (@(posedge clock) disable iff (!rst_n)
    !sleep_clamp |-> sync_in == pad_in)
    else $error("input clamped while awake");

  AST_CLAMP_OVERRIDE: assert property (@(posedge clock) disable iff (!rst_n)
    sleep_clamp |-> ((sync_in ^ pad_in) & (int_en_q | alt_input_override)) == `GPIOP_RST_BYTE)
    else $error("override pin still clamped");

  AST_INT_EN_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && int_en_wr) |=> int_en_q == $past(wdata))
    else $error("interrupt enable write lost");

  AST_EDGE_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && int_edge_wr) |=> int_edge_q == $past(wdata))
    else $error("edge sense write lost");

  AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && int_flag_wr && !wake) |=> (int_flag_q & $past(wdata)) == `GPIOP_RST_BYTE)
    else $error("flag not cleared by write one");

  AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && !int_flag_wr && !wake) |=> int_flag_q == $past(int_flag_q))
    else $error("flag changed without cause");

  AST_NO_FLAG_WITHOUT_WAKE: assert property (@(posedge clock) disable iff (!rst_n)
    !(clk_en && wake) |=> (int_flag_q & ~$past(int_flag_q)) == `GPIOP_RST_BYTE)
    else $error("flag set outside wake");

  AST_RESET_TRISTATE: assert property (@(posedge clock)
    !rst_n |-> (pad.oe == `GPIOP_RST_BYTE) && (pad.out == `GPIOP_RST_BYTE))
    else $error("pin driven during reset");

  AST_RESET_PULLUP_OFF: assert property (@(posedge clock)
    !rst_n |-> pad.pullup_en == `GPIOP_RST_BYTE)
    else $error("pull-up on during reset");

  AST_FREEZE: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> (state_q == $past(state_q)) && (latch_q == $past(latch_q)) && (direction_q == $past(direction_q))
      && (pin_q == $past(pin_q)) && (int_flag_q == $past(int_flag_q)))
    else $error("state moved while clock enable low");

endmodule

/* File: hw/gpiop_sync.sv */
`timescale 1ns/1ps
`include "gpiop_defines.svh"
module gpiop_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Data
  input wire gpiop_pkg::gpiop_byte_t din,
  output gpiop_pkg::gpiop_byte_t sync_q
);
  gpiop_pkg::gpiop_byte_t hold_lat;

  // Open while clock high, holds from the falling edge
  always_latch begin
    if (!rst_n) begin
      hold_lat <= `GPIOP_RST_BYTE;
    end else if (clock && clk_en) begin
      hold_lat <= din;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= `GPIOP_RST_BYTE;
    end else if (clk_en) begin
      sync_q <= hold_lat;
    end
  end
endmodule

/* File: test/gpiop_pad_model.sv */
`timescale 1ns/1ps
module gpiop_pad_model (
  // Clock
  input wire logic clock,
  // Pad controls from the port
  input wire gpiop_pkg::gpiop_pad_t pad,
  // External driver
  input wire gpiop_pkg::gpiop_byte_t ext_en,
  input wire gpiop_pkg::gpiop_byte_t ext_val,
  // Resolved level
  output gpiop_pkg::gpiop_byte_t level
);
  gpiop_pkg::gpiop_byte_t float_q = 8'h5A;
  // Undriven pins wander every cycle
  always @(posedge clock) float_q <= ~level;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = pad.oe[i] ? pad.out[i] : ext_en[i] ? ext_val[i] : pad.pullup_en[i] ? 1'b1 : float_q[i];
    end
  end
endmodule

/* File: test/tb_general_purpose_io_port.sv */
`timescale 1ns/1ps
`include "gpiop_defines.svh"
module tb_general_purpose_io_port;
  logic clock, rst_n, clk_en, hsel, hwrite, sleep_clamp, hreadyout, hresp, dp_rd;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  gpiop_pkg::gpiop_byte_t pad_in, ext_en, ext_val, alt, v, r;
  gpiop_pkg::gpiop_pad_t pad;
  logic [31:0] rd_q[$];
  int bad_count, num_checks;

  gpiop_port i_gpiop_port (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in), .pad(pad),
    .sleep_clamp(sleep_clamp), .alt_input_override(alt));
  gpiop_pad_model i_gpiop_pad_model (.clock(clock), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
    .level(pad_in));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single word transfer; for reads d is the expected byte
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    if (!w) rd_q.push_back({24'h0, d});
    do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      bad_count++;
      complete_run();
    end
  endtask

  task pchk(input logic [7:0] oe, input logic [7:0] pu, input logic [7:0] out);
    #1 chk({8'h0, pad.oe, pad.pullup_en, pad.out & pad.oe}, {8'h0, oe, pu, out & oe});
    @(posedge clock);
  endtask

  // Read data checker
  always @(posedge clock) begin
    if (dp_rd && hreadyout === 1'b1) chk(hrdata, rd_q.pop_front());
    if (dp_rd && hreadyout === 1'b1) chk({31'h0, hresp}, 32'h0);
    if (hreadyout === 1'b1) dp_rd <= hsel & htrans[1] & ~hwrite;
  end

  initial begin
    rst_n = 1'b0; clk_en = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; sleep_clamp = 1'b0; alt = 8'h00; ext_en = 8'h00;
    ext_val = 8'h00; dp_rd = 1'b0;
    void'($urandom(48));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    pchk(8'h00, 8'h00, 8'h00);
    bus(0, `GPIOP_OFS_DIR, 8'h00);
    bus(0, `GPIOP_OFS_LATCH, 8'h00);
    bus(1, 8'h1C, 8'hFF);
    bus(0, 8'h1C, 8'h00);
    r = 8'($urandom);
    bus(1, `GPIOP_OFS_LATCH, r);
    pchk(8'h00, r, 8'h00);
    bus(1, `GPIOP_OFS_CTRL, 8'h01);
    pchk(8'h00, 8'h00, 8'h00);
    bus(0, `GPIOP_OFS_CTRL, 8'h01);
    bus(1, `GPIOP_OFS_CTRL, 8'h00);
    pchk(8'h00, r, 8'h00);
    bus(1, `GPIOP_OFS_DIR, 8'hFF);
    pchk(8'hFF, 8'h00, r);
    bus(0, `GPIOP_OFS_PIN, r);
    bus(1, `GPIOP_OFS_PIN, 8'h0F);
    pchk(8'hFF, 8'h00, r ^ 8'h0F);
    bus(0, `GPIOP_OFS_LATCH, r ^ 8'h0F);
    bus(1, `GPIOP_OFS_DIR, 8'h00);
    bus(1, `GPIOP_OFS_LATCH, 8'h00);
    pchk(8'h00, 8'h00, 8'h00);
    v = 8'($urandom);
    alt <= 8'($urandom);
    ext_en <= 8'hFF;
    ext_val <= v;
    bus(0, `GPIOP_OFS_PIN, v);
    sleep_clamp <= 1'b1;
    bus(0, `GPIOP_OFS_PIN, v & alt);
    bus(1, `GPIOP_OFS_INT_EN, 8'hF0);
    bus(0, `GPIOP_OFS_PIN, v & (alt | 8'hF0));
    bus(1, `GPIOP_OFS_INT_EN, 8'h00);
    bus(1, `GPIOP_OFS_INT_EDGE, 8'hFF);
    ext_val <= 8'hFF;
    sleep_clamp <= 1'b0;
    bus(0, `GPIOP_OFS_INT_FLAG, 8'hFF);
    bus(1, `GPIOP_OFS_INT_FLAG, 8'hFF);
    bus(0, `GPIOP_OFS_INT_FLAG, 8'h00);
    ext_en <= 8'h00;
    bus(1, `GPIOP_OFS_LATCH, 8'hFF);
    pchk(8'h00, 8'hFF, 8'h00);
    clk_en <= 1'b0;
    bus(1, `GPIOP_OFS_LATCH, 8'h00);
    clk_en <= 1'b1;
    bus(0, `GPIOP_OFS_LATCH, 8'hFF);
    @(posedge clock);
    rst_n <= 1'b0;
    clk_en <= 1'b0;
    pchk(8'h00, 8'h00, 8'h00);
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    clk_en <= 1'b1;
    bus(0, `GPIOP_OFS_LATCH, 8'h00);
    complete_run();
  end
endmodule
